// ### dv/sbst_jtag_host.sv
`timescale 1ns/1ps
`default_nettype none
module sbst_jtag_host (
	input wire logic mclk,
	input wire logic tdo,
	input wire logic tdo_oe,
	output logic tck,
	output logic tms,
	output logic tdi
);
	// Test clock stands low between frames; idle lines sit at their pull-up level
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end
	// One test clock of 8 mclk; data out is taken just before the rise
	task automatic step(input logic m, input logic d, output logic q);
		@(posedge mclk);
		tms <= m;
		tdi <= d;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		q = tdo_oe ? tdo : 1'bz;
		@(posedge mclk);
		tck <= 1'b1;
		repeat (4) @(posedge mclk);
		tck <= 1'b0;
	endtask : step
	task automatic scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
		logic q;
		dout = '0;
		step(1'b1, 1'b1, q);
		if (ir) begin
			step(1'b1, 1'b1, q);
		end
		step(1'b0, 1'b1, q);
		step(1'b0, 1'b1, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
	endtask : scan
	task automatic reset_tap();
		logic q;
		repeat (5) step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
	endtask : reset_tap
endmodule : sbst_jtag_host
`default_nettype wire

// ### dv/sbst_tap_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sbst_tap_asserts
	import sbst_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic tck,
	input wire logic tms,
	input wire sbst_mem_pins_type mem_pins,
	input wire logic tdo,
	input wire logic tdo_oe,
	input wire logic outputs_hiz,
	input wire sbst_lane_write_type lane_write
);
	logic [2:0] rel_ff;
	logic [2:0] ones_ff;
	logic tck_ff;
	// Decode checks wait until the synchronisers hold post-reset samples
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rel_ff <= '0;
			ones_ff <= '0;
			tck_ff <= 1'b0;
		end else begin
			rel_ff <= (rel_ff == 3'h7) ? rel_ff : rel_ff + 3'h1;
			tck_ff <= tck;
			if (tck && !tck_ff) begin
				ones_ff <= !tms ? 3'h0 : (ones_ff == 3'h5) ? ones_ff : ones_ff + 3'h1;
			end
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////////
	a_read_sel_follows: assert property (rel_ff == 3'h7 |-> lane_write.read_sel == $past(mem_pins.write_en_n, 3))
		else $error("read select does not follow write enable");
	a_lane_a_write: assert property (rel_ff == 3'h7 |-> lane_write.lane_a_write ==
		(!$past(mem_pins.write_en_n, 3) && !$past(mem_pins.byte_lane_a_select_n, 3)))
		else $error("lane a write decode wrong");
	a_lane_b_write: assert property (rel_ff == 3'h7 |-> lane_write.lane_b_write ==
		(!$past(mem_pins.write_en_n, 3) && !$past(mem_pins.byte_lane_b_select_n, 3)))
		else $error("lane b write decode wrong");
	a_read_no_write: assert property (lane_write.read_sel |-> !lane_write.lane_a_write && !lane_write.lane_b_write)
		else $error("write lane active during read");
	a_oe_on_fall: assert property (!$stable(tdo_oe) |-> !$past(tck) && !$past(tck, 2))
		else $error("data out enable moved outside test clock low phase");
	a_tdo_on_fall: assert property (!$stable(tdo) |-> !$past(tck) && !$past(tck, 2))
		else $error("data out moved outside test clock low phase");
	a_reset_floats: assert property (ones_ff == 3'h5 |-> ##[0:12] (!outputs_hiz && !tdo_oe))
		else $error("five high mode clocks did not reset the port");
	a_lanes_ignore_tap: assert property ((rel_ff == 3'h7 && $stable(mem_pins)) [*4] |=> $stable(lane_write))
		else $error("lane decode moved without memory pin change");
	c_shift: cover property ($rose(tdo_oe));
	c_hiz: cover property ($rose(outputs_hiz));
	c_both_lanes: cover property (lane_write.lane_a_write && lane_write.lane_b_write);
endmodule : sbst_tap_asserts
`default_nettype wire

// ### dv/sbst_tap_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbst_consts.svh"
module sbst_tap_test import sbst_pkg::*;;
	logic mclk, sys_rst, tck, tms, tdi, tdo, tdo_oe, outputs_hiz;
	logic [`SBST_BSR_WIDTH-1:0] pin_ring;
	sbst_mem_pins_type mem_pins;
	sbst_lane_write_type lane_write;
	int fails, samples_checked;
	logic [127:0] rd;
	sbst_tap u_sbst_tap (.mclk(mclk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi),
		.pin_ring(pin_ring), .mem_pins(mem_pins), .tdo(tdo), .tdo_oe(tdo_oe),
		.outputs_hiz(outputs_hiz), .lane_write(lane_write));
	sbst_jtag_host u_sbst_jtag_host (.mclk(mclk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms), .tdi(tdi));
	////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic close_out();
		$display("Mismatches %0d in %0d checks", fails, samples_checked);
		if (fails == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out
	task automatic load_ir(input logic [2:0] code);
		u_sbst_jtag_host.scan(1'b1, 3, {125'h0, code}, rd);
		check("ir capture", rd, 3'h1);
	endtask : load_ir
	////////////////////////////////////////////////////////////////
	task automatic t_power_up();
		logic q;
		@(negedge mclk);
		check("oe", tdo_oe, 1'b0);
		check("hiz", outputs_hiz, 1'b0);
		// Leave test-logic-reset once, without re-entering it, so the scans start from idle
		u_sbst_jtag_host.step(1'b0, 1'b1, q);
		u_sbst_jtag_host.scan(1'b0, 32, '1, rd);
		check("id", rd, `SBST_ID_VALUE);
	endtask : t_power_up
	task automatic t_ring();
		logic [2:0] codes [3] = '{3'h0, 3'h2, 3'h4};
		logic [74:0] pat;
		for (int i = 0; i < 3; i++) begin
			pat = {25{codes[i]}} ^ 75'h5_a5a5_0f0f_3c3c_9696;
			pin_ring <= pat;
			load_ir(codes[i]);
			check("hiz", outputs_hiz, codes[i] != 3'h4);
			u_sbst_jtag_host.scan(1'b0, 75, '0, rd);
			check("ring", rd, pat);
			check("hiz after update", outputs_hiz, codes[i] != 3'h4);
		end
	endtask : t_ring
	task automatic t_bypass();
		load_ir(3'h7);
		check("hiz", outputs_hiz, 1'b0);
		// Captured zero leads, then a one-stage delay of the data in
		u_sbst_jtag_host.scan(1'b0, 8, 8'hb2, rd);
		check("bypass", rd, 8'h64);
		check("oe idle", tdo_oe, 1'b0);
	endtask : t_bypass
	task automatic t_tap_reset();
		mem_pins <= 3'h0;
		load_ir(3'h0);
		u_sbst_jtag_host.reset_tap();
		check("hiz", outputs_hiz, 1'b0);
		check("lanes", lane_write, 3'h3);
		u_sbst_jtag_host.scan(1'b0, 32, '0, rd);
		check("id", rd, `SBST_ID_VALUE);
	endtask : t_tap_reset
	task automatic t_decode();
		for (int m = 0; m < 8; m++) begin
			@(posedge mclk);
			mem_pins <= m[2:0];
			repeat (4) @(posedge mclk);
			@(negedge mclk);
			check("lanes", lane_write, {m[2], m[2:1] == 2'h0, m[2] == 1'b0 && m[0] == 1'b0});
		end
	endtask : t_decode
	////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// A hang in any scan ends the run as a failure
	initial begin
		repeat (60000) @(posedge mclk);
		fails++;
		close_out();
	end
	initial begin
		fails = 0;
		samples_checked = 0;
		sys_rst = 1'b1;
		pin_ring = '0;
		mem_pins = 3'h7;
		repeat (10) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge mclk);
		t_power_up();
		t_ring();
		t_bypass();
		t_tap_reset();
		t_decode();
		close_out();
	end
endmodule : sbst_tap_test
bind sbst_tap sbst_tap_asserts u_sbst_tap_asserts (.mclk(mclk), .sys_rst(sys_rst), .tck(tck), .tms(tms),
	.mem_pins(mem_pins), .tdo(tdo), .tdo_oe(tdo_oe), .outputs_hiz(outputs_hiz), .lane_write(lane_write));
`default_nettype wire

// ### verilog/sbst_consts.svh
`ifndef SBST_CONSTS_SVH
`define SBST_CONSTS_SVH

// Register lengths
`define SBST_IR_WIDTH 3
`define SBST_BSR_WIDTH 75
`define SBST_ID_WIDTH 32

// Instruction codes; the all-zero code is external test
`define SBST_INS_EXTEST 3'h0
`define SBST_INS_IDCODE 3'h1
`define SBST_INS_SAMPLE_Z 3'h2
`define SBST_INS_SAMPLE 3'h4
`define SBST_INS_BYPASS 3'h7

// Pattern loaded into the instruction shift stage in capture-instruction
`define SBST_IR_CAPTURE 3'h1

// Identification code; the value is arbitrary, bit 0 is one as the standard asks
`define SBST_ID_VALUE 32'h0a5c_3e01

// Reset values
`define SBST_BYPASS_CAPTURE 1'b0
`define SBST_PULLUP_LEVEL 1'b1

`endif

// ### verilog/sbst_pkg.sv
`include "sbst_consts.svh"

package sbst_pkg;

	typedef enum logic [3:0] {
		SBST_TLR = 4'h0,
		SBST_RTI = 4'h1,
		SBST_SEL_DR = 4'h3,
		SBST_CAP_DR = 4'h2,
		SBST_SH_DR = 4'h6,
		SBST_EX1_DR = 4'h7,
		SBST_PA_DR = 4'h5,
		SBST_EX2_DR = 4'h4,
		SBST_UP_DR = 4'hc,
		SBST_SEL_IR = 4'hd,
		SBST_CAP_IR = 4'hf,
		SBST_SH_IR = 4'he,
		SBST_EX1_IR = 4'ha,
		SBST_PA_IR = 4'hb,
		SBST_EX2_IR = 4'h9,
		SBST_UP_IR = 4'h8
	} sbst_tap_state_type;

	typedef enum logic [1:0] {
		SBST_DR_BSR = 2'h0,
		SBST_DR_ID = 2'h1,
		SBST_DR_BYP = 2'h2
	} sbst_dr_sel_type;

	// Memory-side write control pins of the x18 variant, all active low
	typedef struct packed {
		logic write_en_n;
		logic byte_lane_a_select_n;
		logic byte_lane_b_select_n;
	} sbst_mem_pins_type;

	// Decoded write enables; each lane enable covers its lane_parity_bit too
	typedef struct packed {
		logic read_sel;
		logic lane_a_write;
		logic lane_b_write;
	} sbst_lane_write_type;

	typedef struct packed {
		logic tck_prev;
		sbst_tap_state_type tap;
		logic [`SBST_IR_WIDTH-1:0] ir;
		logic [`SBST_IR_WIDTH-1:0] ir_shift;
		logic [`SBST_BSR_WIDTH-1:0] bsr;
		logic [`SBST_ID_WIDTH-1:0] id;
		logic byp;
		logic tdo;
		logic tdo_oe;
		logic outputs_hiz;
		sbst_lane_write_type lanes;
	} sbst_state_type;

endpackage : sbst_pkg

// ### verilog/sbst_sync.sv
`timescale 1ns/1ps
`default_nettype none

module sbst_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	// First stage is read only by the second stage
	logic [WIDTH-1:0] stage1_ff;
	logic [WIDTH-1:0] stage2_ff;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			stage1_ff <= RST_VAL;
			stage2_ff <= RST_VAL;
		end else begin
			stage1_ff <= async_in;
			stage2_ff <= stage1_ff;
		end
	end

	assign sync_out = stage2_ff;

endmodule : sbst_sync

`default_nettype wire

// ### verilog/sbst_tap.sv
// Behaviour
// - Sample on test clock rise, drive on fall
// - Mode select steers states, pulled high
// - Data in to MSB, out from LSB
// - Data out driven only in shift states
// - Five high mode clocks reach test-logic-reset
// - Test reset leaves memory operation untouched
// - Power-up reset floats serial data out
// - Instruction selects exactly one data register
// - Three-bit instruction, identification on reset
// - Capture-instruction loads 01 into low bits
// - New instruction acts only after update-instruction
// - Bypass is one bit, captured as zero
// - 75-bit boundary register captures and shifts ring
// - Identification code captured then shifted out
// - No preload; test instructions only capture ring
// - All-zero code samples and floats memory outputs
// - Sample-float selects boundary register, floats outputs
// - Write enable high reads; select pairs decode
// - Bypass instruction puts bypass bit in path
// - Update-data under sample changes nothing
`timescale 1ns/1ps
`default_nettype none

`include "sbst_consts.svh"

module sbst_tap
	import sbst_pkg::*;
#(
	parameter int IR_WIDTH = `SBST_IR_WIDTH,
	parameter int BSR_WIDTH = `SBST_BSR_WIDTH,
	parameter int ID_WIDTH = `SBST_ID_WIDTH,
	parameter logic [`SBST_ID_WIDTH-1:0] ID_VALUE = `SBST_ID_VALUE
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic [`SBST_BSR_WIDTH-1:0] pin_ring,
	input wire sbst_mem_pins_type mem_pins,
	output logic tdo,
	output logic tdo_oe,
	output logic outputs_hiz,
	output sbst_lane_write_type lane_write
);

	////////////////////////////////////////////////////////////////////////////
	// Synchronisers

	logic [`SBST_BSR_WIDTH-1:0] ring_sync;
	logic [2:0] mem_sync;
	logic tck_s;
	logic tms_s;
	logic tdi_s;
	sbst_mem_pins_type mem_s;

	// Test clock idles low, so no false rise follows reset
	sbst_sync #(
		.WIDTH(1),
		.RST_VAL(1'b0)
	) u_tck_sync (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.async_in(tck),
		.sync_out(tck_s)
	);

	// Unconnected mode select and data in read high, as the pull-ups make them
	sbst_sync #(
		.WIDTH(1),
		.RST_VAL(`SBST_PULLUP_LEVEL)
	) u_tms_sync (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.async_in(tms),
		.sync_out(tms_s)
	);

	sbst_sync #(
		.WIDTH(1),
		.RST_VAL(`SBST_PULLUP_LEVEL)
	) u_tdi_sync (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.async_in(tdi),
		.sync_out(tdi_s)
	);

	// The ring may move while it is captured; a value in transition is not guaranteed
	sbst_sync #(
		.WIDTH(`SBST_BSR_WIDTH),
		.RST_VAL('0)
	) u_ring_sync (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.async_in(pin_ring),
		.sync_out(ring_sync)
	);

	// Write controls idle high so nothing is written out of reset
	sbst_sync #(
		.WIDTH(3),
		.RST_VAL(3'h7)
	) u_mem_sync (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.async_in(mem_pins),
		.sync_out(mem_sync)
	);

	assign mem_s = sbst_mem_pins_type'(mem_sync);

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic sbst_tap_state_type tap_next(input sbst_tap_state_type cur, input logic m);
		case (cur)
			SBST_TLR: tap_next = m ? SBST_TLR : SBST_RTI;
			SBST_RTI: tap_next = m ? SBST_SEL_DR : SBST_RTI;
			SBST_SEL_DR: tap_next = m ? SBST_SEL_IR : SBST_CAP_DR;
			SBST_CAP_DR: tap_next = m ? SBST_EX1_DR : SBST_SH_DR;
			SBST_SH_DR: tap_next = m ? SBST_EX1_DR : SBST_SH_DR;
			SBST_EX1_DR: tap_next = m ? SBST_UP_DR : SBST_PA_DR;
			SBST_PA_DR: tap_next = m ? SBST_EX2_DR : SBST_PA_DR;
			SBST_EX2_DR: tap_next = m ? SBST_UP_DR : SBST_SH_DR;
			SBST_UP_DR: tap_next = m ? SBST_SEL_DR : SBST_RTI;
			SBST_SEL_IR: tap_next = m ? SBST_TLR : SBST_CAP_IR;
			SBST_CAP_IR: tap_next = m ? SBST_EX1_IR : SBST_SH_IR;
			SBST_SH_IR: tap_next = m ? SBST_EX1_IR : SBST_SH_IR;
			SBST_EX1_IR: tap_next = m ? SBST_UP_IR : SBST_PA_IR;
			SBST_PA_IR: tap_next = m ? SBST_EX2_IR : SBST_PA_IR;
			SBST_EX2_IR: tap_next = m ? SBST_UP_IR : SBST_SH_IR;
			SBST_UP_IR: tap_next = m ? SBST_SEL_DR : SBST_RTI;
			default: tap_next = SBST_TLR;
		endcase
	endfunction : tap_next

	// Reserved codes are loaded by update-instruction like any other; they fall to bypass so the
	// chain length stays defined when one is loaded
	function automatic sbst_dr_sel_type dr_select(input logic [`SBST_IR_WIDTH-1:0] ins);
		case (ins)
			`SBST_INS_EXTEST: dr_select = SBST_DR_BSR;
			`SBST_INS_SAMPLE: dr_select = SBST_DR_BSR;
			`SBST_INS_SAMPLE_Z: dr_select = SBST_DR_BSR;
			`SBST_INS_IDCODE: dr_select = SBST_DR_ID;
			`SBST_INS_BYPASS: dr_select = SBST_DR_BYP;
			default: dr_select = SBST_DR_BYP;
		endcase
	endfunction : dr_select

	// Only the two floating instructions release the memory outputs; sample and
	// the reserved codes leave them driven
	function automatic logic floats_outputs(input logic [`SBST_IR_WIDTH-1:0] ins);
		case (ins)
			`SBST_INS_EXTEST: floats_outputs = 1'b1;
			`SBST_INS_SAMPLE_Z: floats_outputs = 1'b1;
			`SBST_INS_SAMPLE: floats_outputs = 1'b0;
			`SBST_INS_IDCODE: floats_outputs = 1'b0;
			`SBST_INS_BYPASS: floats_outputs = 1'b0;
			default: floats_outputs = 1'b0;
		endcase
	endfunction : floats_outputs

	// Serial out always comes from bit 0 of the register the instruction picked
	function automatic logic dr_out_bit(input sbst_dr_sel_type sel, input sbst_state_type s);
		case (sel)
			SBST_DR_BSR: dr_out_bit = s.bsr[0];
			SBST_DR_ID: dr_out_bit = s.id[0];
			SBST_DR_BYP: dr_out_bit = s.byp;
			default: dr_out_bit = s.byp;
		endcase
	endfunction : dr_out_bit

	// Write decode as a table; with write enable low, a low select writes its byte lane with its lane_parity_bit
	function automatic sbst_lane_write_type lane_decode(input sbst_mem_pins_type p);
		case ({p.write_en_n, p.byte_lane_a_select_n, p.byte_lane_b_select_n})
			3'h0: lane_decode = '{read_sel: 1'b0, lane_a_write: 1'b1, lane_b_write: 1'b1};
			3'h1: lane_decode = '{read_sel: 1'b0, lane_a_write: 1'b1, lane_b_write: 1'b0};
			3'h2: lane_decode = '{read_sel: 1'b0, lane_a_write: 1'b0, lane_b_write: 1'b1};
			3'h3: lane_decode = '{read_sel: 1'b0, lane_a_write: 1'b0, lane_b_write: 1'b0};
			default: lane_decode = '{read_sel: 1'b1, lane_a_write: 1'b0, lane_b_write: 1'b0};
		endcase
	endfunction : lane_decode

	////////////////////////////////////////////////////////////////////////////
	// State

	sbst_state_type state_ff;
	sbst_state_type nxt_state;
	logic tck_rise;
	logic tck_fall;
	sbst_dr_sel_type dr_sel;

	assign tck_rise = tck_s & ~state_ff.tck_prev;
	assign tck_fall = ~tck_s & state_ff.tck_prev;
	assign dr_sel = dr_select(state_ff.ir);

	always_comb begin
		nxt_state = state_ff;
		nxt_state.tck_prev = tck_s;

		// Rising test clock edge: sample mode select and data in
		if (tck_rise) begin
			nxt_state.tap = tap_next(state_ff.tap, tms_s);
			case (state_ff.tap)
				SBST_CAP_IR: begin
					nxt_state.ir_shift = `SBST_IR_CAPTURE;
				end
				SBST_SH_IR: begin
					nxt_state.ir_shift = {tdi_s, state_ff.ir_shift[IR_WIDTH-1:1]};
				end
				SBST_CAP_DR: begin
					case (dr_sel)
						SBST_DR_BSR: nxt_state.bsr = ring_sync;
						SBST_DR_ID: nxt_state.id = ID_VALUE;
						SBST_DR_BYP: nxt_state.byp = `SBST_BYPASS_CAPTURE;
						default: nxt_state.byp = `SBST_BYPASS_CAPTURE;
					endcase
				end
				SBST_SH_DR: begin
					case (dr_sel)
						SBST_DR_BSR: nxt_state.bsr = {tdi_s, state_ff.bsr[BSR_WIDTH-1:1]};
						SBST_DR_ID: nxt_state.id = {tdi_s, state_ff.id[ID_WIDTH-1:1]};
						SBST_DR_BYP: nxt_state.byp = tdi_s;
						default: nxt_state.byp = tdi_s;
					endcase
				end
				// Update-data has no preload stage behind it, so it acts like a pause
				SBST_UP_DR: begin
					nxt_state.bsr = state_ff.bsr;
				end
				default: begin
					nxt_state.ir_shift = state_ff.ir_shift;
				end
			endcase
			// Entering test-logic-reset restores the identification instruction
			if (nxt_state.tap == SBST_TLR) begin
				nxt_state.ir = `SBST_INS_IDCODE;
				nxt_state.outputs_hiz = 1'b0;
			end
		end

		// Falling test clock edge: drive outputs and commit a new instruction
		if (tck_fall) begin
			case (state_ff.tap)
				SBST_SH_IR: begin
					nxt_state.tdo = state_ff.ir_shift[0];
					nxt_state.tdo_oe = 1'b1;
				end
				SBST_SH_DR: begin
					nxt_state.tdo = dr_out_bit(dr_sel, state_ff);
					nxt_state.tdo_oe = 1'b1;
				end
				SBST_UP_IR: begin
					nxt_state.ir = state_ff.ir_shift;
					nxt_state.outputs_hiz = floats_outputs(state_ff.ir_shift);
					nxt_state.tdo_oe = 1'b0;
				end
				default: begin
					nxt_state.tdo_oe = 1'b0;
				end
			endcase
		end

		// Memory write decode runs on every clock and ignores the test port state
		nxt_state.lanes = lane_decode(mem_s);
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state_ff.tck_prev <= 1'b0;
			state_ff.tap <= SBST_TLR;
			state_ff.ir <= `SBST_INS_IDCODE;
			state_ff.ir_shift <= `SBST_IR_CAPTURE;
			state_ff.bsr <= '0;
			state_ff.id <= '0;
			state_ff.byp <= `SBST_BYPASS_CAPTURE;
			state_ff.tdo <= 1'b0;
			state_ff.tdo_oe <= 1'b0;
			state_ff.outputs_hiz <= 1'b0;
			// Out of reset the memory sees a read, never a stray write
			state_ff.lanes.read_sel <= 1'b1;
			state_ff.lanes.lane_a_write <= 1'b0;
			state_ff.lanes.lane_b_write <= 1'b0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign tdo = state_ff.tdo;
	assign tdo_oe = state_ff.tdo_oe;
	assign outputs_hiz = state_ff.outputs_hiz;
	assign lane_write = state_ff.lanes;

endmodule : sbst_tap

`default_nettype wire
